//--- pwmifb_defines.svh
`ifndef PWMIFB_DEFINES_SVH
`define PWMIFB_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PWMIFB_OFS_COMPAT 12'h03c
`define PWMIFB_OFS_IEN 12'h040
`define PWMIFB_OFS_IND 12'h044
`define PWMIFB_OFS_CAPTURE_CONTROL_ZERO 12'h050
`define PWMIFB_RESET_VAL 32'h0000_0000
// ----------------------------------------
// field positions
// ----------------------------------------
`define PWMIFB_DUTY_LSB 8
`define PWMIFB_PERIOD_LSB 0
`define PWMIFB_TYPE01_BIT 16
`define PWMIFB_TYPE23_BIT 17
`define PWMIFB_CH1_LSB 16
`define PWMIFB_INV_BIT 0
`define PWMIFB_RIE_BIT 1
`define PWMIFB_FIE_BIT 2
`define PWMIFB_CEN_BIT 3
`define PWMIFB_CIF_BIT 4
`define PWMIFB_RLI_BIT 6
`define PWMIFB_FLI_BIT 7
`endif

//--- pwmifb_pkg.sv
`default_nettype none
package pwmifb_pkg;
  // ----------------------------------------
  // per-channel counter strobes
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] duty_match;
    logic [3:0] underflow;
    logic [3:0] period_match;
  } pwmifb_cnt_evt_t;
  // ----------------------------------------
  // capture configuration, channels 1..0
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] input_invert;
    logic [1:0] rise_irq_en;
    logic [1:0] fall_irq_en;
    logic [1:0] capture_en;
  } pwmifb_cap_cfg_t;
endpackage : pwmifb_pkg
`default_nettype wire

//--- pwmifb_top.sv
// What this block does
// [RULE1] down-count reaching compare sets duty flag
// [RULE2] write one clears duty flag, zero keeps
// [RULE3] edge-aligned compare equals period: no duty flag
// [RULE4] pair 2/3 type bit picks period condition
// [RULE5] pair 0/1 type bit picks period condition
// [RULE6] write one clears period flag, zero keeps
// [RULE7] indication register at 0x44, resets zero
// [RULE8] capture control at 0x50, two channel bytes
// [RULE9] center mode: type zero underflow, one match
// [RULE10] latched indicators clear per compatibility bit
// [RULE11] flags interrupt only while enabled
// [RULE12] write one clears capture flag
// [RULE13] interrupt high while any enabled flag set
`include "pwmifb_defines.svh"
`default_nettype none
module pwmifb_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pwmifb_pkg::pwmifb_cnt_evt_t cnt_evt,
  input wire logic center_aligned,
  input wire logic [1:0] rise_evt,
  input wire logic [1:0] fall_evt,
  output pwmifb_pkg::pwmifb_cap_cfg_t cap_cfg,
  output logic irq
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // set wins over a clear landing in the same cycle
  function automatic logic [3:0] flag_next(input logic [3:0] cur, input logic [3:0] set,
                                           input logic [3:0] clr);
    flag_next = set | (cur & ~clr);
  endfunction : flag_next

  function automatic logic [7:0] ch_byte(input logic [31:0] w, input logic ch);
    ch_byte = ch ? w[`PWMIFB_CH1_LSB +: 8] : w[7:0];
  endfunction : ch_byte

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [3:0] duty_flag_q, duty_flag_d, period_flag_q, period_flag_d;
  logic [3:0] duty_ie_q, duty_ie_d, period_ie_q, period_ie_d;
  logic pair01_period_sel_q, pair01_period_sel_d;
  logic pair23_period_sel_q, pair23_period_sel_d;
  logic compat_clear_sel_q, compat_clear_sel_d;
  logic [1:0] inv_q, inv_d, rie_q, rie_d, fie_q, fie_d, cen_q, cen_d;
  logic [1:0] cif_q, cif_d, rli_q, rli_d, fli_q, fli_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;

  logic acc, wr, sel_compat, sel_ien, sel_ind, sel_ccr, mapped;
  logic [3:0] period_set;
  logic [1:0] cif_set, cif_clr, rli_clr, fli_clr;
  logic [7:0] b0, b1;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // one wait state: pready rises in the second access cycle
  assign acc = psel && penable;
  assign wr = acc && pwrite && pready_q;
  assign sel_compat = paddr == `PWMIFB_OFS_COMPAT;
  assign sel_ien = paddr == `PWMIFB_OFS_IEN;
  assign sel_ind = paddr == `PWMIFB_OFS_IND;
  assign sel_ccr = paddr == `PWMIFB_OFS_CAPTURE_CONTROL_ZERO;
  assign mapped = sel_compat || sel_ien || sel_ind || sel_ccr;
  assign b0 = ch_byte(pwdata, 1'b0);
  assign b1 = ch_byte(pwdata, 1'b1);

  // ----------------------------------------
  // flag and config next state
  // ----------------------------------------
  always_comb begin
    period_ie_d = period_ie_q;
    duty_ie_d = duty_ie_q;
    pair01_period_sel_d = pair01_period_sel_q;
    pair23_period_sel_d = pair23_period_sel_q;
    compat_clear_sel_d = compat_clear_sel_q;
    inv_d = inv_q;
    rie_d = rie_q;
    fie_d = fie_q;
    cen_d = cen_q;
    if (wr && sel_compat) begin
      compat_clear_sel_d = pwdata[0];
    end
    if (wr && sel_ien) begin
      period_ie_d = pwdata[`PWMIFB_PERIOD_LSB +: 4];
      duty_ie_d = pwdata[`PWMIFB_DUTY_LSB +: 4];
      pair01_period_sel_d = pwdata[`PWMIFB_TYPE01_BIT];
      pair23_period_sel_d = pwdata[`PWMIFB_TYPE23_BIT];
    end
    if (wr && sel_ccr) begin
      inv_d = {b1[`PWMIFB_INV_BIT], b0[`PWMIFB_INV_BIT]};
      rie_d = {b1[`PWMIFB_RIE_BIT], b0[`PWMIFB_RIE_BIT]};
      fie_d = {b1[`PWMIFB_FIE_BIT], b0[`PWMIFB_FIE_BIT]};
      cen_d = {b1[`PWMIFB_CEN_BIT], b0[`PWMIFB_CEN_BIT]};
    end
    // edge-aligned: underflow always; center: type bit chooses
    for (int n = 0; n < 4; n++) begin
      if (!center_aligned) begin
        period_set[n] = cnt_evt.underflow[n];
      end else if (n < 2) begin
        period_set[n] = pair01_period_sel_q ? cnt_evt.period_match[n] // RULE5 RULE9
                                            : cnt_evt.underflow[n];
      end else begin
        period_set[n] = pair23_period_sel_q ? cnt_evt.period_match[n] // RULE4 RULE9
                                            : cnt_evt.underflow[n];
      end
    end
    // duty strobe comes from the counter, which skips it when compare equals period
    duty_flag_d = flag_next(duty_flag_q, cnt_evt.duty_match, // RULE1 RULE3
                            (wr && sel_ind) ? pwdata[`PWMIFB_DUTY_LSB +: 4] : 4'h0); // RULE2
    period_flag_d = flag_next(period_flag_q, period_set,
                              (wr && sel_ind) ? pwdata[`PWMIFB_PERIOD_LSB +: 4] : 4'h0); // RULE6
    // capture flag needs the matching edge enable
    cif_set = cen_q & ((rise_evt & rie_q) | (fall_evt & fie_q));
    cif_clr = (wr && sel_ccr) ? {b1[`PWMIFB_CIF_BIT], b0[`PWMIFB_CIF_BIT]} : 2'h0;
    cif_d = 2'(flag_next({2'h0, cif_q}, {2'h0, cif_set}, {2'h0, cif_clr})); // RULE12
    // indicators clear on written zero when compat is clear, or on written one when compat is set
    rli_clr = 2'h0;
    fli_clr = 2'h0;
    if (wr && sel_ccr) begin
      rli_clr = {b1[`PWMIFB_RLI_BIT], b0[`PWMIFB_RLI_BIT]} ^ {2{~compat_clear_sel_q}}; // RULE10
      fli_clr = {b1[`PWMIFB_FLI_BIT], b0[`PWMIFB_FLI_BIT]} ^ {2{~compat_clear_sel_q}}; // RULE10
    end
    rli_d = 2'(flag_next({2'h0, rli_q}, {2'h0, cen_q & rise_evt}, {2'h0, rli_clr}));
    fli_d = 2'(flag_next({2'h0, fli_q}, {2'h0, cen_q & fall_evt}, {2'h0, fli_clr}));
    irq_d = |(duty_flag_d & duty_ie_d) || |(period_flag_d & period_ie_d) // RULE11 RULE13
            || |(cif_d & cen_d); // RULE13
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  always_comb begin
    pready_d = acc && !pready_q;
    pslverr_d = acc && !pready_q && !mapped;
    prdata_d = prdata_q;
    if (acc && !pready_q) begin
      prdata_d = `PWMIFB_RESET_VAL;
      if (sel_compat) begin
        prdata_d[0] = compat_clear_sel_q;
      end
      if (sel_ien) begin
        prdata_d[`PWMIFB_PERIOD_LSB +: 4] = period_ie_q;
        prdata_d[`PWMIFB_DUTY_LSB +: 4] = duty_ie_q;
        prdata_d[`PWMIFB_TYPE01_BIT] = pair01_period_sel_q;
        prdata_d[`PWMIFB_TYPE23_BIT] = pair23_period_sel_q;
      end
      if (sel_ind) begin
        prdata_d[`PWMIFB_PERIOD_LSB +: 4] = period_flag_q; // RULE7
        prdata_d[`PWMIFB_DUTY_LSB +: 4] = duty_flag_q; // RULE7
      end
      if (sel_ccr) begin
        for (int c = 0; c < 2; c++) begin
          prdata_d[c*16 + `PWMIFB_INV_BIT] = inv_q[c]; // RULE8
          prdata_d[c*16 + `PWMIFB_RIE_BIT] = rie_q[c];
          prdata_d[c*16 + `PWMIFB_FIE_BIT] = fie_q[c];
          prdata_d[c*16 + `PWMIFB_CEN_BIT] = cen_q[c];
          prdata_d[c*16 + `PWMIFB_CIF_BIT] = cif_q[c];
          prdata_d[c*16 + `PWMIFB_RLI_BIT] = rli_q[c];
          prdata_d[c*16 + `PWMIFB_FLI_BIT] = fli_q[c];
        end
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_flag_q <= 4'h0; // RULE7
      period_flag_q <= 4'h0;
      duty_ie_q <= 4'h0;
      period_ie_q <= 4'h0;
      pair01_period_sel_q <= 1'b0;
      pair23_period_sel_q <= 1'b0;
      compat_clear_sel_q <= 1'b0;
      inv_q <= 2'h0; // RULE8
      rie_q <= 2'h0;
      fie_q <= 2'h0;
      cen_q <= 2'h0;
      cif_q <= 2'h0;
      rli_q <= 2'h0;
      fli_q <= 2'h0;
      prdata_q <= `PWMIFB_RESET_VAL;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      duty_flag_q <= duty_flag_d;
      period_flag_q <= period_flag_d;
      duty_ie_q <= duty_ie_d;
      period_ie_q <= period_ie_d;
      pair01_period_sel_q <= pair01_period_sel_d;
      pair23_period_sel_q <= pair23_period_sel_d;
      compat_clear_sel_q <= compat_clear_sel_d;
      inv_q <= inv_d;
      rie_q <= rie_d;
      fie_q <= fie_d;
      cen_q <= cen_d;
      cif_q <= cif_d;
      rli_q <= rli_d;
      fli_q <= fli_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign cap_cfg = '{input_invert: inv_q, rise_irq_en: rie_q,
                     fall_irq_en: fie_q, capture_en: cen_q};

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready_q;
  endsequence

  a_apb_one_wait: assert property (s_setup ##1 s_wait |=> pready_q)
    else $error("pready not after one wait");
  a_duty_set_ch0: assert property (cnt_evt.duty_match[0] |=> duty_flag_q[0]) // RULE1
    else $error("duty flag not set");
  a_duty_w1c: assert property (wr && sel_ind && pwdata[8] && !cnt_evt.duty_match[0] // RULE2
                               |=> !duty_flag_q[0])
    else $error("duty flag not cleared");
  a_duty_w0_keep: assert property (wr && sel_ind && !pwdata[8] && duty_flag_q[0] // RULE2
                                   |=> duty_flag_q[0])
    else $error("duty flag lost on zero write");
  a_period_pair01: assert property (center_aligned && pair01_period_sel_q // RULE5
                                    && cnt_evt.period_match[1] |=> period_flag_q[1])
    else $error("pair01 match not flagged");
  a_period_pair23: assert property (center_aligned && !pair23_period_sel_q // RULE4
                                    && !cnt_evt.underflow[3] && !cnt_evt.period_match[3]
                                    && !period_flag_q[3] |=> !period_flag_q[3])
    else $error("pair23 flag set without cause");
  a_period_center: assert property (center_aligned && !pair01_period_sel_q // RULE9
                                    && cnt_evt.underflow[0] |=> period_flag_q[0])
    else $error("underflow not flagged");
  a_period_w1c: assert property (wr && sel_ind && pwdata[2] && !period_set[2] // RULE6
                                 |=> !period_flag_q[2])
    else $error("period flag not cleared");
  a_ind_reserved: assert property (pready_q && sel_ind |-> prdata_q[31:12] == 20'h0 // RULE7
                                   && prdata_q[7:4] == 4'h0)
    else $error("indication reserved bits set");
  a_ccr_reserved: assert property (pready_q && sel_ccr |-> prdata_q[31:24] == 8'h0 // RULE8
                                   && prdata_q[15:8] == 8'h0 && !prdata_q[5])
    else $error("capture reserved bits set");
  a_latch_clear: assert property (wr && sel_ccr && (pwdata[6] == compat_clear_sel_q) // RULE10
                                  && !(cen_q[0] && rise_evt[0]) |=> !rli_q[0])
    else $error("rise indicator not cleared");
  a_capflag_w1c: assert property (wr && sel_ccr && pwdata[4] && !cif_set[0] // RULE12
                                  |=> !cif_q[0])
    else $error("capture flag not cleared");
  a_irq_level: assert property (irq_q == (|(duty_flag_q & duty_ie_q) // RULE11 RULE13
                                || |(period_flag_q & period_ie_q) || |(cif_q & cen_q)))
    else $error("irq mismatch with flags");

  sequence s_done;
    psel && penable && pready_q;
  endsequence
  a_unmapped_err: assert property (s_setup ##1 s_wait ##0 !mapped |=> pslverr_q && pready_q)
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (s_done ##0 mapped |-> !pslverr_q)
    else $error("error on mapped register");
  a_ready_pulse: assert property (pready_q |=> !pready_q)
    else $error("pready longer than one cycle");
  a_period_edge: assert property (!center_aligned && cnt_evt.underflow[2] |=> period_flag_q[2]) // RULE4
    else $error("edge underflow not flagged");
  a_capflag_set: assert property (cen_q[0] && rie_q[0] && rise_evt[0] |=> cif_q[0]) // RULE12
    else $error("capture flag not set");
  a_fall_latched: assert property (cen_q[0] && fall_evt[0] |=> fli_q[0]) // RULE10
    else $error("fall indicator not set");
  a_irq_on_duty: assert property (duty_ie_q[0] && cnt_evt.duty_match[0] && !(wr && sel_ien) // RULE11 RULE13
                                  |=> irq_q)
    else $error("irq missing after duty event");

endmodule : pwmifb_top
`default_nettype wire

//--- pwmifb_top_tb.sv
`default_nettype none
module pwmifb_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pwmifb_pkg::pwmifb_cnt_evt_t cnt_evt;
  logic center_aligned;
  logic [1:0] rise_evt;
  logic [1:0] fall_evt;
  pwmifb_pkg::pwmifb_cap_cfg_t cap_cfg;
  logic irq;
  int errors = 0;
  int checked = 0;

  pwmifb_top u_pwmifb_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cnt_evt(cnt_evt), .center_aligned(center_aligned),
    .rise_evt(rise_evt), .fall_evt(fall_evt), .cap_cfg(cap_cfg), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // master waits for pready itself; values read at an edge are those before its updates
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, exp, r);
  endtask : rd

  task automatic pulse(input logic [3:0] du, input logic [3:0] un, input logic [3:0] pm);
    @(posedge pclk);
    cnt_evt <= {du, un, pm};
    @(posedge pclk);
    cnt_evt <= 12'h000;
  endtask : pulse

  // irq is a level, so sample it settled at a falling edge
  task automatic irqc(input logic exp);
    repeat (2) @(negedge pclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask : irqc
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(12'h044, 32'h0000_0000, "indication reset");
    rd(12'h050, 32'h0000_0000, "capture reset");
    rd(12'h040, 32'h0000_0000, "enable reset");
    irqc(1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_duty;
    wr(12'h040, 32'h0000_0f00);
    pulse(4'hf, 4'h0, 4'h0);
    rd(12'h044, 32'h0000_0f00, "duty set");
    irqc(1'b1);
    wr(12'h044, 32'h0000_0500);
    rd(12'h044, 32'h0000_0a00, "duty w1c");
    wr(12'h044, 32'h0000_0000);
    rd(12'h044, 32'h0000_0a00, "duty w0 keeps");
    wr(12'h044, 32'h0000_0a00);
    irqc(1'b0);
    $display("test duty done");
  endtask : t_duty

  task automatic t_period;
    logic [3:0] eu;
    wr(12'h040, 32'h0000_000f);
    pulse(4'h0, 4'hf, 4'h0);
    rd(12'h044, 32'h0000_000f, "edge underflow");
    wr(12'h044, 32'h0000_0005);
    rd(12'h044, 32'h0000_000a, "period w1c");
    wr(12'h044, 32'h0000_000a);
    center_aligned <= 1'b1;
    // every combination of the two pair selects
    for (int s = 0; s < 4; s++) begin
      eu = {{2{~s[1]}}, {2{~s[0]}}};
      wr(12'h040, {14'h0, s[1:0], 16'h000f});
      pulse(4'h0, 4'hf, 4'h0);
      rd(12'h044, {28'h0, eu}, "center underflow");
      wr(12'h044, 32'h0000_000f);
      pulse(4'h0, 4'h0, 4'hf);
      rd(12'h044, {28'h0, ~eu}, "center match");
      wr(12'h044, 32'h0000_000f);
    end
    center_aligned <= 1'b0;
    $display("test period done");
  endtask : t_period

  task automatic t_mask;
    wr(12'h040, 32'h0000_0000);
    pulse(4'h1, 4'h1, 4'h0);
    rd(12'h044, 32'h0000_0101, "masked flags");
    irqc(1'b0);
    wr(12'h040, 32'h0000_0100);
    irqc(1'b1);
    wr(12'h040, 32'h0000_0001);
    irqc(1'b1);
    wr(12'h044, 32'h0000_0001);
    irqc(1'b0);
    wr(12'h044, 32'h0000_0100);
    $display("test mask done");
  endtask : t_mask

  task automatic t_capture;
    wr(12'h03c, 32'h0000_0001);
    wr(12'h050, 32'h000e_000f);
    // cap_cfg updates on the completing edge, so look once it has settled
    @(negedge pclk);
    chk("cap_cfg", 32'h0000_007f, {24'h0, cap_cfg});
    @(posedge pclk);
    rise_evt <= 2'b11;
    @(posedge pclk);
    rise_evt <= 2'b00;
    rd(12'h050, 32'h005e_005f, "capture set");
    irqc(1'b1);
    wr(12'h050, 32'h001e_001f);
    rd(12'h050, 32'h004e_004f, "capflag w1c");
    wr(12'h050, 32'h004e_004f);
    rd(12'h050, 32'h000e_000f, "latched w1 clears");
    irqc(1'b0);
    wr(12'h03c, 32'h0000_0000);
    @(posedge pclk);
    fall_evt <= 2'b01;
    @(posedge pclk);
    fall_evt <= 2'b00;
    rd(12'h050, 32'h000e_009f, "fall set");
    wr(12'h050, 32'h001e_009f);
    rd(12'h050, 32'h000e_008f, "w1 keeps latched");
    wr(12'h050, 32'h000e_000f);
    rd(12'h050, 32'h000e_000f, "w0 clears latched");
    $display("test capture done");
  endtask : t_capture

  task automatic t_unmapped;
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h048, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    wr(12'h048, 32'hffff_ffff);
    rd(12'h044, 32'h0000_0000, "after unmapped");
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cnt_evt = 12'h000;
    center_aligned = 1'b0;
    rise_evt = 2'b00;
    fall_evt = 2'b00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_duty();
    t_period();
    t_mask();
    t_capture();
    t_unmapped();
    print_verdict();
  end

  // whole run is a few hundred cycles; this allows ample margin
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule : pwmifb_top_tb
`default_nettype wire
